/* csb_pkg.sv */
package csb_pkg;
    // Register byte offsets on the APB
    localparam logic [7:0] OFF_FLASH_BASE   = 8'h00;
    localparam logic [7:0] OFF_FLASH_OPTION = 8'h04;
    localparam logic [7:0] OFF_SRAM_BASE    = 8'h08;
    localparam logic [7:0] OFF_SRAM_OPTION  = 8'h0c;
    localparam logic [7:0] OFF_R2_BASE      = 8'h10;
    localparam logic [7:0] OFF_R2_OPTION    = 8'h14;
    localparam logic [7:0] OFF_PERIPH_BASE  = 8'h18;
    localparam logic [7:0] OFF_PERIPH_OPTION = 8'h1c;
    localparam logic [7:0] OFF_MAP_CTRL     = 8'h20;
    localparam logic [7:0] OFF_STATUS       = 8'h24;

    // Reset values of the region registers
    localparam logic [31:0] RST_FLASH_BASE    = 32'h0080_0003;
    localparam logic [31:0] RST_FLASH_OPTION  = 32'hffe0_0030;
    localparam logic [31:0] RST_SRAM_BASE     = 32'hfff0_0003;
    localparam logic [31:0] RST_SRAM_OPTION   = 32'hfff0_0000;
    localparam logic [31:0] RST_R2_BASE       = 32'h0000_0000;
    localparam logic [31:0] RST_R2_OPTION     = 32'h0000_0000;
    localparam logic [31:0] RST_PERIPH_BASE   = 32'h0100_0807;
    localparam logic [31:0] RST_PERIPH_OPTION = 32'hffff_80f0;

    // Base register fields
    localparam int BR_VALID_BIT  = 0;
    localparam int BR_PS_LSB     = 1;  // Port size, 2 bits
    localparam int BR_ETA_BIT    = 11; // External acknowledge
    // Option register fields
    localparam int OR_WAIT_LSB   = 4;  // 4-bit wait count
    localparam logic [3:0] WAIT_EXTERNAL = 4'hf;
    localparam logic [31:0] ADDR_MASK    = 32'hffff_8000;

    // Port sizes
    localparam logic [1:0] PS_32 = 2'b01;
    localparam logic [1:0] PS_16 = 2'b11;

    // Reset vectors and internal map
    localparam logic [31:0] VEC_LOW    = 32'h0000_0100;
    localparam logic [31:0] VEC_HIGH   = 32'hfff0_0100;
    localparam logic [31:0] IFLASH_LO  = 32'h0000_0000;
    localparam logic [31:0] IFLASH_HI  = 32'h0007_ffff;
    localparam logic [31:0] IFCTL_LO   = 32'h002f_c000;
    localparam logic [31:0] IFCTL_HI   = 32'h002f_ffff;
    localparam int IFLASH_BLOCKS = 8;
    localparam int IFLASH_BLK_LSB = 16; // 64 Kbyte blocks
    localparam logic [31:0] MONITOR_BASE = 32'h0090_0000;

    typedef enum logic [1:0] {CSB_IDLE, CSB_WAIT, CSB_DONE} csb_state_t;
endpackage : csb_pkg

/* csb_decoder.sv */
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module csb_decoder
    import csb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_req,
    input  wire logic [31:0] bus_addr,
    input  wire logic        transfer_ack_n,
    input  wire logic        boot_vector_high_select,
    output logic             boot_region_select_n,
    output logic             region1_select_n,
    output logic             region2_select_n,
    output logic             region3_select_n,
    output logic             internal_flash_sel,
    output logic             internal_flash_ctl_sel,
    output logic      [2:0]  internal_flash_block,
    output logic      [1:0]  port_size,
    output logic             bus_ack,
    output logic      [31:0] reset_vector
);

    // Register storage, regions indexed 0..3
    // Region registers are whole words; map control holds bit 0 only and status is read-only
    logic [31:0] base_q [4];
    logic [31:0] base_d [4];
    logic [31:0] opt_q  [4];
    logic [31:0] opt_d  [4];
    logic        boot_global_q, boot_global_d;
    logic        flash_array_enable_q, flash_array_enable_d;
    logic        vec_cap_q, vec_cap_d;
    logic [31:0] vec_q, vec_d;

    // Masked base compare, shared by all regions
    function automatic logic region_hit(input logic [31:0] a,
                                        input logic [31:0] br,
                                        input logic [31:0] orr);
        region_hit = br[BR_VALID_BIT] &&
                     (((a ^ br) & orr & ADDR_MASK) == 32'h0000_0000);
    endfunction : region_hit

    // Region index from register offset
    function automatic logic [1:0] reg_region(input logic [7:0] a);
        reg_region = a[4:3];
    endfunction : reg_region

    // One-hot active-low select for a region index
    function automatic logic [3:0] select_lines(input logic [1:0] idx);
        select_lines = ~(4'b0001 << idx);
    endfunction : select_lines

    // Region register offsets: below map control, word aligned
    function automatic logic is_region_reg(input logic [7:0] a);
        is_region_reg = (a < OFF_MAP_CTRL) && (a[1:0] == 2'b00);
    endfunction : is_region_reg

    // Inclusive address window test
    function automatic logic in_window(input logic [31:0] a,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
        in_window = (a >= lo) && (a <= hi);
    endfunction : in_window

    // APB write path and config state
    // Writes land at the access edge only; a setup cycle alone
    // never changes state, so an abandoned transfer is harmless
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            base_d[i] = base_q[i];
            opt_d[i]  = opt_q[i];
        end
        boot_global_d        = boot_global_q;
        flash_array_enable_d = flash_array_enable_q;
        vec_cap_d = 1'b1;
        vec_d     = vec_q;
        // Strap is sampled after release, never under reset
        if (!vec_cap_q) begin
            vec_d = boot_vector_high_select ? VEC_HIGH : VEC_LOW;
        end
        if (psel && penable && pwrite) begin
            if (is_region_reg(paddr)) begin
                if (paddr[2]) begin
                    opt_d[reg_region(paddr)] = pwdata;
                    if (reg_region(paddr) == 2'd0) begin
                        boot_global_d = 1'b0;
                    end
                end else begin
                    base_d[reg_region(paddr)] = pwdata;
                end
            end else if (paddr == OFF_MAP_CTRL) begin
                flash_array_enable_d = pwdata[0];
            end
        end
    end

    // Config registers; reset loads the boot-time region map
    // Region 2 resets invalid so it never steals a decode
    always_ff @(posedge clk) begin
        if (reset) begin
            base_q[0] <= RST_FLASH_BASE;
            opt_q[0]  <= RST_FLASH_OPTION;
            base_q[1] <= RST_SRAM_BASE;
            opt_q[1]  <= RST_SRAM_OPTION;
            base_q[2] <= RST_R2_BASE;
            opt_q[2]  <= RST_R2_OPTION;
            base_q[3] <= RST_PERIPH_BASE;
            opt_q[3]  <= RST_PERIPH_OPTION;
            boot_global_q        <= 1'b1;
            flash_array_enable_q <= 1'b1;
            vec_cap_q <= 1'b0;
            vec_q     <= VEC_LOW;
        end else begin
            for (int i = 0; i < 4; i++) begin
                base_q[i] <= base_d[i];
                opt_q[i]  <= opt_d[i];
            end
            boot_global_q        <= boot_global_d;
            flash_array_enable_q <= flash_array_enable_d;
            vec_cap_q <= vec_cap_d;
            vec_q     <= vec_d;
        end
    end

    // APB read path; zero-wait slave, error on unmapped
    logic [31:0] prdata_d;
    logic        pslverr_d;
    logic        pready_d;
    csb_state_t  st_q, st_d;

    // Reads decode in setup so data is a flop output when
    // the master samples it in the access phase
    always_comb begin
        prdata_d  = 32'h0000_0000;
        pslverr_d = 1'b0;
        pready_d  = psel && !penable;
        if (psel && !penable) begin
            if (is_region_reg(paddr)) begin
                prdata_d = paddr[2] ? opt_q[reg_region(paddr)]
                                    : base_q[reg_region(paddr)];
            end else if (paddr == OFF_MAP_CTRL) begin
                prdata_d = {31'h0000_0000, flash_array_enable_q};
            end else if (paddr == OFF_STATUS) begin
                // Bit 3 shows a beat stalled on its terminate
                prdata_d = {28'h000_0000, (st_q == CSB_WAIT),
                            vec_q == VEC_HIGH, boot_global_q,
                            flash_array_enable_q};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // Answer registered in setup, ready in access phase
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pslverr <= pslverr_d;
            pready  <= pready_d;
        end
    end

    // Address decode of the memory bus
    // Internal targets override the chip selects, so a region
    // programmed over them never drives a pin for those cycles
    logic [3:0] hit;
    logic       if_arr, if_ctl;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            hit[i] = region_hit(bus_addr, base_q[i], opt_q[i]);
        end
        // Boot select answers every address outside the internal targets until option 0 written
        if (boot_global_q) begin
            hit = 4'b0001;
        end
        // Internal flash, 512 Kbytes, gated by enable
        if_arr = flash_array_enable_q &&
                 in_window(bus_addr, IFLASH_LO, IFLASH_HI);
        if_ctl = flash_array_enable_q &&
                 in_window(bus_addr, IFCTL_LO, IFCTL_HI);
        if (if_arr || if_ctl) begin
            hit = 4'b0000;
        end
    end

    // Selected region: lowest index wins on overlap
    // Overlap is a setup error; fixed priority keeps the
    // select lines one-hot whatever software writes
    logic [1:0] sel_idx;
    always_comb begin
        sel_idx = 2'd0;
        for (int i = 3; i >= 0; i--) begin
            if (hit[i]) begin
                sel_idx = 2'(i);
            end
        end
    end

    // Bus cycle sequencer: wait count or external ack
    // One beat at a time: a request is only taken in idle,
    // and done gives the bus one quiet cycle between beats
    // Next values of the pin flops follow
    logic [3:0]  wcnt_q, wcnt_d;
    logic [1:0]  cur_q, cur_d;
    logic [3:0]  cs_n_d;
    logic        ack_d;
    logic [1:0]  ps_d;
    logic        ifs_d, ifc_d;
    logic [2:0]  blk_d;

    always_comb begin
        st_d   = st_q;
        wcnt_d = wcnt_q;
        cur_d  = cur_q;
        cs_n_d = 4'hf;
        ack_d  = 1'b0;
        ps_d   = port_size;
        ifs_d  = 1'b0;
        ifc_d  = 1'b0;
        blk_d  = internal_flash_block;
        case (st_q)
            CSB_IDLE: begin
                // Internal targets ack at once; they have no pin cycle
                if (bus_req && (if_arr || if_ctl)) begin
                    ifs_d = if_arr;
                    ifc_d = if_ctl;
                    blk_d = bus_addr[IFLASH_BLK_LSB +: 3];
                    ack_d = 1'b1;
                    st_d  = CSB_DONE;
                end else if (bus_req && hit != 4'b0000) begin
                    cur_d  = sel_idx;
                    cs_n_d = select_lines(sel_idx);
                    ps_d   = base_q[sel_idx][BR_PS_LSB +: 2];
                    wcnt_d = opt_q[sel_idx][OR_WAIT_LSB +: 4];
                    if (wcnt_d == 4'h0 &&
                        !base_q[sel_idx][BR_ETA_BIT]) begin
                        ack_d = 1'b1;
                        st_d  = CSB_DONE;
                    end else begin
                        st_d  = CSB_WAIT;
                    end
                end
            end
            CSB_WAIT: begin
                // A wait count of F also means external terminate
                cs_n_d = select_lines(cur_q);
                if (base_q[cur_q][BR_ETA_BIT] ||
                    wcnt_q == WAIT_EXTERNAL) begin
                    // External terminate only; no count ends it
                    if (!transfer_ack_n) begin
                        ack_d = 1'b1;
                        st_d  = CSB_DONE;
                    end
                end else if (wcnt_q <= 4'h1) begin
                    ack_d = 1'b1;
                    st_d  = CSB_DONE;
                end else begin
                    wcnt_d = wcnt_q - 4'h1;
                end
            end
            CSB_DONE: begin
                // Bus drops request for a cycle between beats
                st_d = CSB_IDLE;
            end
            default: begin
                st_d = CSB_IDLE;
            end
        endcase
    end

    // Every pin output is a flop, so pin timing does not
    // depend on the depth of the decode
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q   <= CSB_IDLE;
            wcnt_q <= 4'h0;
            cur_q  <= 2'd0;
            boot_region_select_n   <= 1'b1;
            region1_select_n       <= 1'b1;
            region2_select_n       <= 1'b1;
            region3_select_n       <= 1'b1;
            internal_flash_sel     <= 1'b0;
            internal_flash_ctl_sel <= 1'b0;
            internal_flash_block   <= 3'd0;
            port_size <= PS_32;
            bus_ack   <= 1'b0;
        end else begin
            st_q   <= st_d;
            wcnt_q <= wcnt_d;
            cur_q  <= cur_d;
            boot_region_select_n   <= cs_n_d[0];
            region1_select_n       <= cs_n_d[1];
            region2_select_n       <= cs_n_d[2];
            region3_select_n       <= cs_n_d[3];
            internal_flash_sel     <= ifs_d;
            internal_flash_ctl_sel <= ifc_d;
            internal_flash_block   <= blk_d;
            port_size <= ps_d;
            bus_ack   <= ack_d;
        end
    end

    // Fetch address after reset, latched from strap
    // Stays until the next reset; no write path exists
    assign reset_vector = vec_q;

    // Constants kept for software but unused by the logic;
    // tied together here so they stay referenced
    logic unused_ok;
    assign unused_ok = (MONITOR_BASE != 32'h0) && (IFLASH_BLOCKS == 8) &&
                       (PS_16 != PS_32);

endmodule : csb_decoder

/* csb_decoder_properties.sv */
`timescale 1ns/1ps
module csb_checker
    import csb_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        bus_req,
    input wire logic        transfer_ack_n,
    input wire logic        boot_vector_high_select,
    input wire logic        boot_region_select_n,
    input wire logic        region1_select_n,
    input wire logic        region2_select_n,
    input wire logic        region3_select_n,
    input wire logic [1:0]  port_size,
    input wire logic        bus_ack,
    input wire logic [31:0] reset_vector
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // High while no select is driven low
    wire logic none_sel = &{boot_region_select_n, region1_select_n,
                            region2_select_n, region3_select_n};

    a_one_select: assert property ($onehot0(~{boot_region_select_n,
        region1_select_n, region2_select_n, region3_select_n}))
        else $error("two selects low at once");
    a_select_needs_req: assert property ($fell(none_sel) |->
        $past(bus_req)) else $error("select without a request");
    a_sram_zero_wait: assert property ($fell(region1_select_n) |->
        bus_ack ##1 region1_select_n) else $error("sram beat not one cycle");
    a_flash_three_wait: assert property ($fell(boot_region_select_n) |->
        (!boot_region_select_n && !bus_ack)[*3] ##1
        (!boot_region_select_n && bus_ack)) else $error("flash wait wrong");
    a_periph_ext_ack: assert property (bus_ack && !region3_select_n |->
        !$past(transfer_ack_n)) else $error("peripheral ended without ack");
    a_periph_ack_next: assert property (!region3_select_n &&
        !transfer_ack_n && !bus_ack |=> bus_ack)
        else $error("peripheral ack not followed");
    a_periph_port16: assert property (!region3_select_n |->
        port_size == PS_16) else $error("peripheral port not 16 bit");
    a_vector_strap: assert property ($fell(reset) |=> reset_vector ==
        ($past(boot_vector_high_select) ? VEC_HIGH : VEC_LOW))
        else $error("reset vector does not follow strap");
    // Main scenarios reached
    cover property ($fell(region3_select_n));
    cover property ($fell(region1_select_n));
    cover property ($fell(reset));
endmodule : csb_checker

bind csb_decoder csb_checker csb_checker_inst (.clk, .reset, .bus_req,
    .transfer_ack_n, .boot_vector_high_select, .boot_region_select_n,
    .region1_select_n, .region2_select_n, .region3_select_n, .port_size,
    .bus_ack, .reset_vector);

/* csb_periph_model.sv */
`timescale 1ns/1ps
module csb_periph_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       region3_select_n,
    input  wire logic [3:0] ack_delay,
    output logic            transfer_ack_n
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // Cycles spent selected; saturates so a long stall cannot wrap
    always_comb begin
        cnt_d = region3_select_n ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
    end
    always_ff @(posedge clk) begin
        cnt_q <= reset ? 4'h0 : cnt_d;
    end
    // Pulled-up line: ack only while selected and the delay has run
    assign transfer_ack_n = region3_select_n || cnt_q < ack_delay;
endmodule : csb_periph_model

/* chip_select_boot_decoder_bench.sv */
`timescale 1ns/1ps
module chip_select_boot_decoder_bench;
    import csb_pkg::*;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic bus_req = 0, boot_vector_high_select = 1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, bus_addr = 32'h0, prdata, reset_vector, rd;
    logic pready, pslverr, transfer_ack_n, boot_region_select_n, er, f;
    logic region1_select_n, region2_select_n, region3_select_n, bus_ack;
    logic internal_flash_sel, internal_flash_ctl_sel;
    logic [2:0] internal_flash_block;
    logic [1:0] port_size;
    logic [3:0] ack_dly = 4'h0, s;
    int fail_count = 0, num_checks = 0, cyc = 0, n;
    logic [31:0] rst[8] = '{RST_FLASH_BASE, RST_FLASH_OPTION, RST_SRAM_BASE,
        RST_SRAM_OPTION, RST_R2_BASE, RST_R2_OPTION, RST_PERIPH_BASE,
        RST_PERIPH_OPTION};
    // Address, selects seen low, cycles to ack (0: never)
    logic [39:0] rows[11] = '{{32'h0080_0000, 4'he, 4'h4},
        {32'h009f_fffc, 4'he, 4'h4}, {32'h0090_0000, 4'he, 4'h4},
        {32'hfff0_0000, 4'hd, 4'h1}, {32'hfff7_fffc, 4'hd, 4'h1},
        {32'hfff6_0000, 4'hd, 4'h1}, {32'h0100_0000, 4'h7, 4'h2},
        {32'h0100_7ffe, 4'h7, 4'h2}, {32'h0100_8000, 4'hf, 4'h0},
        {32'hffef_fffc, 4'hf, 4'h0}, {32'h00a0_0000, 4'hf, 4'h0}};

    csb_decoder csb_decoder_inst (.clk, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_req, .bus_addr,
        .transfer_ack_n, .boot_vector_high_select, .boot_region_select_n,
        .region1_select_n, .region2_select_n, .region3_select_n,
        .internal_flash_sel, .internal_flash_ctl_sel, .internal_flash_block,
        .port_size, .bus_ack, .reset_vector);
    csb_periph_model csb_periph_model_inst (.clk, .reset, .region3_select_n,
        .ack_delay(ack_dly), .transfer_ack_n);

    always #5 clk = ~clk;
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; holds until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        // Only the bench timeout ends a slave that never answers
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // One memory beat; collects every select seen low and the ack delay
    // Whole-word beats only: no narrow flash write is ever made
    task automatic mem(input logic [31:0] a);
        @(posedge clk);
        bus_req <= 1;
        bus_addr <= a;
        n = 0;
        f = 0;
        s = 4'hf;
        for (int k = 1; k <= 10 && n == 0; k++) begin
            @(posedge clk);
            f = f | internal_flash_sel | internal_flash_ctl_sel;
            s = s & {region3_select_n, region2_select_n, region1_select_n,
                     boot_region_select_n};
            if (bus_ack === 1'b1)
                n = k - 1;
        end
        bus_req <= 0;
    endtask : mem

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, rst[i]);
        end
        chk(reset_vector, VEC_HIGH);
        mem(32'h0100_0000);
        chk(32'(s), 32'he);
        // Same option value again: only the boot-wide decode ends
        apb(1'b1, OFF_FLASH_OPTION, RST_FLASH_OPTION);
        foreach (rows[i]) begin
            mem(rows[i][39:8]);
            chk(32'(s), 32'(rows[i][7:4]));
            chk(32'(n), 32'(rows[i][3:0]));
        end
        ack_dly <= 4'h5;
        mem(32'h0100_0000);
        chk(32'(n), 32'h7);
        chk(32'(port_size), 32'(PS_16));
        ack_dly <= 4'h0;
        mem(32'h0007_0000);
        chk(32'(f), 32'h1);
        chk(32'(internal_flash_block), 32'h7);
        mem(32'h002f_c000);
        chk(32'(f), 32'h1);
        apb(1'b1, OFF_MAP_CTRL, 32'h0);
        mem(32'h0007_0000);
        chk(32'(f), 32'h0);
        mem(32'h002f_c000);
        chk(32'(f), 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        // Second reset with the low vector strap
        reset <= 1;
        boot_vector_high_select <= 0;
        repeat (2) @(posedge clk);
        reset <= 0;
        repeat (3) @(posedge clk);
        chk(reset_vector, VEC_LOW);
        mem(32'hfff0_0000);
        chk(32'(s), 32'he);
        chk(32'(n), 32'h4);
        close_out();
    end
endmodule : chip_select_boot_decoder_bench
